// ==== hdl/hhc_ms_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
// Counts whole milliseconds while run is high; holds when run is low
module hhc_ms_timer #(
    parameter int CNT_W     = 28,
    parameter int MS_CYCLES = 25000
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clear,
    input  wire logic             run,
    output logic [CNT_W-1:0]      ms_count
);
    localparam int PW = $clog2(MS_CYCLES + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(MS_CYCLES - 1);

    logic [PW-1:0] pre;

    generate
        if (MS_CYCLES < 1 || CNT_W < 1) begin : g_bad_cfg
            $error("hhc_ms_timer: MS_CYCLES and CNT_W must be at least 1");
        end
    endgenerate

    // Prescaler keeps its partial count across pauses so time is not lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre <= '0;
        end else if (clear) begin
            pre <= '0;
        end else if (run) begin
            pre <= (pre == PRE_LAST) ? '0 : pre + 1'b1;
        end
    end

    // Millisecond count saturates instead of wrapping
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_count <= '0;
        end else if (clear) begin
            ms_count <= '0;
        end else if (run && pre == PRE_LAST && ms_count != '1) begin
            ms_count <= ms_count + 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== hdl/hhc_pkg.sv ====
package hhc_pkg;

    // Bus geometry
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int IDX_W  = 14;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_ACC_TIMER  = 14'h100a;
    localparam logic [IDX_W-1:0] IDX_START_OPT  = 14'h100e;
    localparam logic [IDX_W-1:0] IDX_PAUSE_CTRL = 14'h100f;
    localparam logic [IDX_W-1:0] IDX_HOLDOFF    = 14'h1010;
    localparam logic [IDX_W-1:0] IDX_STATUS     = 14'h1030;

    // Field widths
    localparam int ACC_W   = 28;
    localparam int HOLD_W  = 8;
    localparam int SO_W    = 6;
    localparam int PC_W    = 3;

    // Reset values
    localparam logic [ACC_W-1:0]  ACC_TIMER_RST  = 28'h000000a;
    localparam logic [SO_W-1:0]   START_OPT_RST  = 6'h38;
    localparam logic [PC_W-1:0]   PAUSE_CTRL_RST = 3'h0;
    localparam logic [HOLD_W-1:0] HOLDOFF_RST    = 8'h00;

    // Start option bit positions
    localparam int SO_PERSIST   = 0;
    localparam int SO_SINGLE    = 1;
    localparam int SO_QUICK     = 2;
    localparam int SO_DLY_PLOCK = 3;
    localparam int SO_DLY_FLOCK = 4;
    localparam int SO_DLY_SLEW  = 5;

    // Pause control bit positions
    localparam int PC_PUNLOCK = 0;
    localparam int PC_FUNLOCK = 1;
    localparam int PC_SLEW    = 2;

    // Quick start divides the timer by four
    localparam int QUICK_SHIFT = 2;

    // Millisecond timebase
    localparam int CLK_NS          = 40;
    localparam int MS_NS           = 1000000;
    localparam int MS_CYCLES_DFLT  = MS_NS / CLK_NS;

    typedef enum logic [3:0] {
        st_idle = 4'b0001,
        st_wait = 4'b0010,
        st_hold = 4'b0100,
        st_run  = 4'b1000
    } hhc_state_e;

    typedef struct packed {
        logic [ACC_W-1:0]  acc_timer;
        logic [HOLD_W-1:0] holdoff;
        logic [SO_W-1:0]   start_opt;
        logic [PC_W-1:0]   pause_ctrl;
    } hhc_cfg_s;

    typedef struct packed {
        logic in_holdover;
        logic phase_locked;
        logic freq_locked;
        logic slew_limiting;
    } hhc_loop_s;

endpackage

// ==== hdl/hhc_top.sv ====
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module hhc_top
    import hhc_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DFLT
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire hhc_loop_s         loop_status,
    output logic                   hist_accumulate,
    output logic                   hist_reset,
    output logic                   hist_ready,
    output logic                   use_last_word
);
    generate
        if (MS_CYCLES < 1) begin : g_bad_ms
            $error("hhc_top: MS_CYCLES must be at least 1");
        end
    endgenerate

    hhc_cfg_s          cfg;
    hhc_state_e        state;
    hhc_state_e        next_state;
    hhc_loop_s         loop_prev;
    logic [ACC_W-1:0]  acc_count;
    logic [HOLD_W-1:0] hold_count;
    logic [ACC_W-1:0]  target;
    logic              start_ok;
    logic              pause_ok;
    logic              reset_evt;
    logic              acc_run;
    logic              hold_done;
    logic              wr_en;
    logic              rd_en;

    // Address decode shared by read and write paths
    function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
        return addr[ADDR_W-1:2];
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        logic [IDX_W-1:0] idx;
        idx = reg_index(addr);
        return (addr[1:0] == 2'b00) &&
               (idx == IDX_ACC_TIMER || idx == IDX_START_OPT ||
                idx == IDX_PAUSE_CTRL || idx == IDX_HOLDOFF || idx == IDX_STATUS);
    endfunction

    // Zero-wait slave: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !is_mapped(paddr);
    assign wr_en   = psel && penable && pwrite && is_mapped(paddr);
    assign rd_en   = psel && !penable && !pwrite;

    // Configuration registers; status is read-only and ignores writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg.acc_timer  <= ACC_TIMER_RST;
            cfg.holdoff    <= HOLDOFF_RST;
            cfg.start_opt  <= START_OPT_RST;
            cfg.pause_ctrl <= PAUSE_CTRL_RST;
        end else if (wr_en) begin
            unique case (reg_index(paddr))
                IDX_ACC_TIMER:  cfg.acc_timer  <= pwdata[ACC_W-1:0];
                IDX_HOLDOFF:    cfg.holdoff    <= pwdata[HOLD_W-1:0];
                IDX_START_OPT:  cfg.start_opt  <= pwdata[SO_W-1:0];
                IDX_PAUSE_CTRL: cfg.pause_ctrl <= pwdata[PC_W-1:0];
                default: ;
            endcase
        end
    end

    // Read data is captured in the setup cycle so it leaves a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (rd_en) begin
            prdata <= '0;
            // Refused reads steer to an unmapped index so they return zero
            unique case (is_mapped(paddr) ? reg_index(paddr) : '0)
                IDX_ACC_TIMER:  prdata[ACC_W-1:0]  <= cfg.acc_timer;
                IDX_HOLDOFF:    prdata[HOLD_W-1:0] <= cfg.holdoff;
                IDX_START_OPT:  prdata[SO_W-1:0]   <= cfg.start_opt;
                IDX_PAUSE_CTRL: prdata[PC_W-1:0]   <= cfg.pause_ctrl;
                IDX_STATUS:     prdata[7:0]        <= {state, use_last_word, hist_ready,
                                                       hist_reset, hist_accumulate};
                default: ;
            endcase
        end
    end

    // Start gate: each enabled settle condition must hold, disabled ones pass
    always_comb begin
        start_ok = (!cfg.start_opt[SO_DLY_PLOCK] || loop_status.phase_locked)
                && (!cfg.start_opt[SO_DLY_FLOCK] || loop_status.freq_locked)
                && (!cfg.start_opt[SO_DLY_SLEW]  || !loop_status.slew_limiting);
    end

    // Pause gate evaluated only once averaging has started
    always_comb begin
        pause_ok = (!cfg.pause_ctrl[PC_SLEW]    || !loop_status.slew_limiting)
                && (!cfg.pause_ctrl[PC_FUNLOCK] || loop_status.freq_locked)
                && (!cfg.pause_ctrl[PC_PUNLOCK] || !loop_status.slew_limiting);
    end

    // Edge history of the loop status; assume holdover before the first lock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_prev <= '{in_holdover: 1'b1, phase_locked: 1'b0,
                           freq_locked: 1'b0, slew_limiting: 1'b0};
        end else begin
            loop_prev <= loop_status;
        end
    end

    // History reset causes; persistence masks every one of them
    always_comb begin
        reset_evt = !cfg.start_opt[SO_PERSIST] && (
                    (loop_prev.in_holdover && !loop_status.in_holdover)
                 || (cfg.pause_ctrl[PC_SLEW] &&
                     !loop_prev.phase_locked && loop_status.phase_locked)
                 || (cfg.pause_ctrl[PC_FUNLOCK] &&
                     !loop_prev.freq_locked && loop_status.freq_locked)
                 || (cfg.pause_ctrl[PC_PUNLOCK] &&
                     loop_prev.slew_limiting && !loop_status.slew_limiting));
    end

    // Hold-off of zero means no delay at all
    assign hold_done = (hold_count >= cfg.holdoff);

    // Acquisition sequencer; entering holdover always parks it
    always_comb begin
        next_state = state;
        unique case (state)
            st_idle: if (!loop_status.in_holdover) next_state = st_wait;
            st_wait: if (start_ok) next_state = st_hold;
            st_hold: if (hold_done) next_state = st_run;
            st_run:  next_state = st_run;
        endcase
        if (loop_status.in_holdover) begin
            next_state = st_idle;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= st_idle;
        end else begin
            state <= next_state;
        end
    end

    // Averaging runs only in the run state with every pause gate open
    assign acc_run = (state == st_run) && pause_ok && !reset_evt;

    hhc_ms_timer #(
        .CNT_W     (HOLD_W),
        .MS_CYCLES (MS_CYCLES)
    ) u_holdoff_timer (
        .pclk     (pclk),
        .presetn  (presetn),
        .clear    (state != st_hold),
        .run      (state == st_hold),
        .ms_count (hold_count)
    );

    // Paused time keeps the count; with persistence off, the lock or slew edges of enabled pauses still clear it
    hhc_ms_timer #(
        .CNT_W     (ACC_W),
        .MS_CYCLES (MS_CYCLES)
    ) u_accum_timer (
        .pclk     (pclk),
        .presetn  (presetn),
        .clear    (reset_evt),
        .run      (acc_run),
        .ms_count (acc_count)
    );

    // Required averaging time; a zero result is raised to one millisecond
    always_comb begin
        target = cfg.start_opt[SO_QUICK] ? (cfg.acc_timer >> QUICK_SHIFT)
                                         : cfg.acc_timer;
        if (target == '0) begin
            target = ACC_W'(1);
        end
    end

    // Registered outputs toward the tuning word averager
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist_accumulate <= 1'b0;
            hist_reset      <= 1'b0;
            hist_ready      <= 1'b0;
            use_last_word   <= 1'b0;
        end else begin
            hist_accumulate <= acc_run;
            hist_reset      <= reset_evt;
            hist_ready      <= !reset_evt && (acc_count >= target);
            use_last_word   <= cfg.start_opt[SO_SINGLE]
                               && (reset_evt || acc_count < target);
        end
    end
endmodule
`default_nettype wire

// ==== tb/hhc_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
// Register and loop-status driven checks of the history control
module hhc_bench
    import hhc_pkg::*;
();
    localparam int MSC = 4;
    localparam logic [15:0] RA [5] = '{16'h4028, 16'h4038, 16'h403c, 16'h4040, 16'h40c0};
    localparam logic [31:0] RV [5] = '{32'ha, 32'h38, 32'h0, 32'h0, 32'h10};
    localparam logic [31:0] PB [3] = '{32'h0, 32'h1, 32'h4};
    logic              pclk    = 1'b0;
    logic              presetn = 1'b0;
    logic              psel    = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite  = 1'b0;
    logic [ADDR_W-1:0] paddr   = 16'h0;
    logic [DATA_W-1:0] pwdata  = 32'h0;
    logic [DATA_W-1:0] prdata;
    logic              pready, pslverr, er, rs, ac;
    logic              hist_accumulate, hist_reset, hist_ready, use_last_word;
    logic [31:0]       rd;
    hhc_loop_s         ls      = hhc_loop_s'(4'he);
    int                n_errors = 0;
    int                checks_done = 0;
    int                c;

    hhc_top #(.MS_CYCLES(MSC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .loop_status(ls),
        .hist_accumulate(hist_accumulate), .hist_reset(hist_reset),
        .hist_ready(hist_ready), .use_last_word(use_last_word));

    // Free-running 25 MHz clock
    initial begin
        forever #20 pclk = ~pclk;
    end

    task final_report;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask

    // One transfer; holds the request until pready is seen high at an edge
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n == 50) n_errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task setls(input logic [3:0] v);
        @(posedge pclk);
        ls <= hhc_loop_s'(v);
    endtask

    // Runs n cycles, noting any reset pulse or accumulation seen
    task run(input int n);
        rs = 1'b0;
        ac = 1'b0;
        repeat (n) begin
            @(posedge pclk);
            #1;
            rs |= hist_reset;
            ac |= hist_accumulate;
        end
    endtask

    // Cycles until accumulation or ready shows; bounded so a hang is caught
    task waitfor(input logic rdy);
        c = 0;
        while ((rdy ? hist_ready : hist_accumulate) !== 1'b1 && c < 60) begin
            @(posedge pclk);
            #1;
            c++;
        end
    endtask

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        final_report;
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk("outs", 32'h0, {hist_accumulate, hist_reset, hist_ready, use_last_word});
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, RA[i], 32'h0);
            chk("reset_val", RV[i], rd);
        end
        apb(1'b1, 16'h403c, 32'hffffffff);
        apb(1'b1, 16'h403e, 32'h0);
        chk("misalign_err", 32'h1, er);
        apb(1'b0, 16'h403c, 32'h0);
        chk("pause_rb", 32'h7, rd);
        apb(1'b0, 16'h403e, 32'h0);
        chk("misalign_rd", 32'h1, {rd[30:0], er});
        apb(1'b0, 16'h4000, 32'h0);
        chk("unmapped", 32'h1, {rd[30:0], er});
        apb(1'b1, 16'h4028, 32'hffffffff);
        apb(1'b0, 16'h4028, 32'h0);
        chk("timer_width", 32'h0fffffff, rd);
        // Phase-lock gate, hold-off and averaging period
        apb(1'b1, 16'h4028, 32'h2);
        apb(1'b1, 16'h4040, 32'h1);
        apb(1'b1, 16'h4038, 32'h8);
        apb(1'b1, 16'h403c, 32'h0);
        setls(4'ha);
        setls(4'h2);
        run(10);
        chk("reacq_reset", 32'h1, rs);
        chk("gated_acc", 32'h0, ac);
        setls(4'h6);
        waitfor(1'b0);
        chk("holdoff", 32'h1, c >= 4 && c <= 9);
        waitfor(1'b1);
        chk("period", 32'h1, c >= 7 && c <= 10);
        apb(1'b0, 16'h40c0, 32'h0);
        chk("status_run", 32'h85, rd);
        // Quick start with single sample fallback
        setls(4'he);
        run(3);
        apb(1'b1, 16'h4040, 32'h0);
        apb(1'b1, 16'h4028, 32'h8);
        apb(1'b1, 16'h4038, 32'h6);
        setls(4'h6);
        run(3);
        chk("single", 32'h1, use_last_word);
        waitfor(1'b1);
        chk("quick", 32'h1, c >= 4 && c <= 12);
        run(2);
        chk("single_off", 32'h0, use_last_word);
        // Persistence against frequency unlock pauses
        apb(1'b1, 16'h4038, 32'h1);
        apb(1'b1, 16'h403c, 32'h2);
        setls(4'he);
        run(3);
        setls(4'h6);
        run(6);
        chk("persist", 32'h1, {rs, ac});
        setls(4'h4);
        run(4);
        chk("freq_pause", 32'h0, hist_accumulate);
        setls(4'h6);
        run(5);
        chk("persist_relock", 32'h0, rs);
        apb(1'b1, 16'h4038, 32'h0);
        setls(4'h4);
        run(4);
        setls(4'h6);
        run(5);
        chk("freq_relock", 32'h1, rs);
        // Slewing with no pause, the phase unlock pause and the slew pause; disabled ones must not stop averaging
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, 16'h403c, PB[i]);
            setls(4'h3);
            run(4);
            chk("slew_acc", PB[i] == 32'h0, hist_accumulate);
            setls(4'h6);
            run(4);
            chk("slew_reset", PB[i] != 32'h0, rs);
        end
        final_report;
    end
endmodule

bind hhc_top hhc_top_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .loop_status(loop_status),
    .hist_accumulate(hist_accumulate), .hist_reset(hist_reset),
    .hist_ready(hist_ready), .use_last_word(use_last_word));
`default_nettype wire

// ==== tb/hhc_top_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// Watches the top ports and ties history outputs to their causes
module hhc_top_checker
    import hhc_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DFLT
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire hhc_loop_s         loop_status,
    input wire logic              hist_accumulate,
    input wire logic              hist_reset,
    input wire logic              hist_ready,
    input wire logic              use_last_word
);
    wire logic hold = loop_status.in_holdover;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Access phase of a transfer, and history held ready for two cycles
    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_ready2;
        hist_ready [*2];
    endsequence
    a_ready_high: assert property (pready) else $error("pready low");
    a_misalign_err: assert property (s_acc ##0 paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access without error");
    a_mapped_ok: assert property (s_acc ##0
        paddr inside {16'h4028, 16'h4038, 16'h403c, 16'h4040, 16'h40c0} |-> !pslverr)
        else $error("mapped access flagged as error");
    a_err_rdzero: assert property (s_acc ##0 (pslverr && !pwrite) |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_reset_single: assert property (
        hist_reset ##0 $stable(loop_status) |=> !hist_reset)
        else $error("history reset wider than one cycle");
    a_reset_clears: assert property (hist_reset |-> ##[0:1] !hist_ready)
        else $error("ready survived a history reset");
    a_hold_stops: assert property (hold [*3] |-> !hist_accumulate)
        else $error("accumulating in holdover");
    a_accum_cause: assert property (hist_accumulate |-> !$past(hold, 2))
        else $error("accumulation without a reference");
    a_last_word: assert property (s_ready2 |-> !use_last_word)
        else $error("single sample used with history ready");
endmodule
`default_nettype wire
